// *** logic/cfl_fifo.sv ***
// Flop-based byte buffer with valid and ready on both sides.
// Assumes one clock for both sides and a depth that is a power of two.
`timescale 1ns/1ps
`include "cfl_params.svh"

module cfl_fifo
	import cfl_pkg::*;
#(
	parameter int WIDTH = `CFL_BYTE_W,
	parameter int DEPTH = `CFL_FIFO_DEPTH
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// All storage and pointers in one record
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} cfl_fifo_state_s;

	cfl_fifo_state_s st_reg;
	cfl_fifo_state_s st_next;
	logic push;
	logic pop;

	// Honest flags straight from the fill count
	assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
	assign out_valid = (st_reg.count != '0);
	assign out_data = st_reg.mem[st_reg.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		st_next = st_reg;
		// Write side
		if (push)
		begin
			st_next.mem[st_reg.wr_ptr] = in_data;
			st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
		end
		// Read side
		if (pop)
			st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
		// Count moves only when one side acts alone
		if (push && !pop)
			st_next.count = st_reg.count + 1'b1;
		else if (pop && !push)
			st_next.count = st_reg.count - 1'b1;
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

endmodule // cfl_fifo

// *** logic/cfl_loader.sv ***
// Configuration loader: fills the configuration cells from flash, a passive
// master, the test port or mask memory, then releases user mode.
// Assumes a 10 MHz sys_clk as the internal oscillator; link_clk comes from
// the passive master or the test clock and may stop between frames.
`timescale 1ns/1ps
`include "cfl_params.svh"

module cfl_loader
	import cfl_pkg::*;
#(
	parameter int CFG_BYTES = `CFL_CFG_BYTES,
	parameter int HOLD_LOW_CYC = `CFL_HOLD_LOW_CYC,
	parameter int WAKE_WAIT_CYC = `CFL_WAKE_WAIT_CYC,
	parameter int FIFO_DEPTH = `CFL_FIFO_DEPTH
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic configuration_restart_n,
	input wire logic [1:0] cfg_mode_strap,
	output cfl_spi_s flash_spi,
	input wire logic flash_miso,
	input wire logic link_clk,
	input wire logic ps_sel_n,
	input wire logic ps_data,
	input wire logic jtag_shift_en,
	input wire logic jtag_tdi,
	output logic mpm_rd_en,
	output logic [23:0] mpm_addr,
	input wire logic [7:0] mpm_data,
	output cfl_cmem_s cmem_wr,
	input wire logic cmem_wr_ready,
	output logic user_mode,
	output logic cfg_busy,
	output logic link_overrun
);
	// Size and timing at register width
	localparam logic [23:0] CFG_BYTES_W = 24'(CFG_BYTES);
	localparam logic [15:0] HOLD_W = 16'(HOLD_LOW_CYC);
	localparam logic [15:0] WAIT_W = 16'(WAKE_WAIT_CYC);
	localparam logic [7:0] HALF_W = 8'(`CFL_SPI_HALF_CYC - 1);

	cfl_sys_s r_reg;         // System-domain state
	cfl_sys_s r_next;        // Its next value
	cfl_link_s l_reg;        // Link-domain state
	cfl_link_s l_next;       // Its next value
	logic fifo_in_ready;     // Buffer can take the pending byte
	logic fifo_out_valid;    // Buffer holds a byte for the cells
	logic fifo_out_ready;    // Cell writer can take a byte
	logic [7:0] fifo_out_data;
	logic link_frame;        // Passive select or test shift active
	logic link_bit;          // Bit presented on this link edge

	// Last byte of the bitstream reached
	function automatic logic last_byte(input logic [23:0] cnt);
		last_byte = (cnt + 24'h1 == CFG_BYTES_W);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link domain: deserialise passive or test-port bits
	// master supplies clock
	assign link_frame = !ps_sel_n || jtag_shift_en;
	assign link_bit = !ps_sel_n ? ps_data : jtag_tdi;

	// Shift in MSB first; a toggle flags each whole byte
	always_comb
	begin
		l_next = l_reg;
		if (link_frame)
		begin
			l_next.sr = {l_reg.sr[5:0], link_bit};
			l_next.cnt = l_reg.cnt + 3'h1;
			if (l_reg.cnt == 3'h7)
			begin
				l_next.hold = {l_reg.sr, link_bit};
				l_next.tog = !l_reg.tog;
			end
		end
		else
			// Idle edge drops a partial byte
			l_next.cnt = 3'h0;
	end

	// Link state register
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
			l_reg <= '0;
		else
			l_reg <= l_next;
	end

	////////////////////////////////////////////////////////////////////////
	// System domain: sequencer, flash engine and cell writer
	// Writer takes a byte when its output slot is free
	assign fifo_out_ready = !r_reg.cmem.valid || cmem_wr_ready;

	always_comb
	begin
		r_next = r_reg;
		// Two-flop synchronisers for the restart pin, mode strap, flash data and link toggle
		r_next.rsn_s1 = configuration_restart_n;
		r_next.rsn_s2 = r_reg.rsn_s1;
		r_next.rsn_prev = r_reg.rsn_s2;
		r_next.mode_s1 = cfg_mode_strap;
		r_next.mode_s2 = r_reg.mode_s1;
		r_next.miso_s1 = flash_miso;
		r_next.miso_s2 = r_reg.miso_s1;
		r_next.tog_s1 = l_reg.tog;
		r_next.tog_s2 = r_reg.tog_s1;
		r_next.tog_prev = r_reg.tog_s2;

		// Pending byte leaves for the buffer
		if (r_reg.pend_valid && fifo_in_ready)
			r_next.pend_valid = 1'b0;

		if (r_reg.cmem.valid && cmem_wr_ready)
		begin
			r_next.cmem.valid = 1'b0;
			r_next.wr_cnt = r_reg.wr_cnt + 24'h1;
		end
		if (fifo_out_valid && fifo_out_ready)
		begin
			r_next.cmem.valid = 1'b1;
			r_next.cmem.addr = r_next.wr_cnt;
			r_next.cmem.data = fifo_out_data;
		end

		case (r_reg.seq)
			// Wait for a qualified restart edge
			CFL_IDLE:
			begin
				if (r_reg.rsn_s2 && !r_reg.rsn_prev && r_reg.low_cnt >= HOLD_W)
				begin
					r_next.mode = cfl_mode_e'(r_reg.mode_s2);
					r_next.fetch_cnt = 24'h0;
					r_next.wr_cnt = 24'h0;
					r_next.mpm_addr = 24'h0;
					r_next.overrun = 1'b0;
					case (cfl_mode_e'(r_reg.mode_s2))
						CFL_M_ACTIVE:
						begin
							r_next.seq = CFL_WAKE;
							r_next.spi.cs_n = 1'b0;
							r_next.tx = {`CFL_OP_WAKE, 32'h0};
							r_next.bit_cnt = `CFL_WAKE_BITS;
							r_next.div_cnt = HALF_W;
						end
						CFL_M_MASK:
							r_next.seq = CFL_MASK;
						default:
							r_next.seq = CFL_LINK;
					endcase
				end
			end
			// Shift out a command, MSB first
			CFL_WAKE, CFL_RDCMD:
			begin
				if (r_reg.div_cnt != 8'h0)
					r_next.div_cnt = r_reg.div_cnt - 8'h1;
				else
				begin
					r_next.div_cnt = HALF_W;
					if (!r_reg.spi.sclk)
						r_next.spi.sclk = 1'b1;
					else
					begin
						r_next.spi.sclk = 1'b0;
						r_next.tx = {r_reg.tx[38:0], 1'b0};
						r_next.bit_cnt = r_reg.bit_cnt - 6'h1;
						if (r_reg.bit_cnt == 6'h1)
						begin
							if (r_reg.seq == CFL_WAKE)
							begin
								r_next.spi.cs_n = 1'b1;
								r_next.seq = CFL_WAIT;
								r_next.wait_cnt = WAIT_W - 16'h1;
							end
							else
							begin
								// Data follows the dummy byte
								r_next.seq = CFL_STREAM;
								r_next.rx_bits = 3'h0;
							end
						end
					end
				end
			end
			// Flash wake-up time
			CFL_WAIT:
			begin
				if (r_reg.wait_cnt != 16'h0)
					r_next.wait_cnt = r_reg.wait_cnt - 16'h1;
				else
				begin
					r_next.seq = CFL_RDCMD;
					r_next.spi.cs_n = 1'b0;
					r_next.tx = {`CFL_OP_FAST_READ, `CFL_START_ADDR, `CFL_DUMMY_BYTE};
					r_next.bit_cnt = `CFL_READ_BITS;
					r_next.div_cnt = HALF_W;
				end
			end
			// Sequential read of the bitstream
			CFL_STREAM:
			begin
				if (r_reg.div_cnt != 8'h0)
					r_next.div_cnt = r_reg.div_cnt - 8'h1;
				else if (!r_reg.spi.sclk)
				begin
					// Clock held low while a byte waits: back-pressure
					if (!r_reg.pend_valid)
					begin
						r_next.spi.sclk = 1'b1;
						r_next.div_cnt = HALF_W;
					end
				end
				else
				begin
					r_next.spi.sclk = 1'b0;
					r_next.div_cnt = HALF_W;
					r_next.rx = {r_reg.rx[6:0], r_reg.miso_s2};
					r_next.rx_bits = r_reg.rx_bits + 3'h1;
					if (r_reg.rx_bits == 3'h7)
					begin
						r_next.pend_data = {r_reg.rx[6:0], r_reg.miso_s2};
						r_next.pend_valid = 1'b1;
						r_next.fetch_cnt = r_reg.fetch_cnt + 24'h1;
						if (last_byte(r_reg.fetch_cnt))
						begin
							r_next.spi.cs_n = 1'b1;
							r_next.seq = CFL_DONE;
						end
					end
				end
			end
			// Bytes from the passive master or the test port
			CFL_LINK:
			begin
				if (r_reg.tog_s2 != r_reg.tog_prev)
				begin
					// Held word is stable once its toggle is seen
					if (r_next.pend_valid)
						r_next.overrun = 1'b1;
					else
					begin
						r_next.pend_data = l_reg.hold;
						r_next.pend_valid = 1'b1;
						r_next.fetch_cnt = r_reg.fetch_cnt + 24'h1;
						if (last_byte(r_reg.fetch_cnt))
							r_next.seq = CFL_DONE;
					end
				end
			end
			// Read from mask memory, one cycle latency
			CFL_MASK:
			begin
				if (r_reg.mpm_rd)
				begin
					r_next.mpm_rd = 1'b0;
					r_next.pend_data = mpm_data;
					r_next.pend_valid = 1'b1;
					r_next.mpm_addr = r_reg.mpm_addr + 24'h1;
					r_next.fetch_cnt = r_reg.fetch_cnt + 24'h1;
					if (last_byte(r_reg.fetch_cnt))
						r_next.seq = CFL_DONE;
				end
				else if (!r_next.pend_valid)
					r_next.mpm_rd = 1'b1;
			end
			// All fetched; release once every cell is written
			CFL_DONE:
			begin
				if (r_reg.wr_cnt == CFG_BYTES_W && !r_reg.pend_valid && !fifo_out_valid)
					r_next.user_mode = 1'b1;
			end
			default:
				r_next.seq = CFL_IDLE;
		endcase

		// Restart pin low aborts the sequence, user mode, flash frame and mask read, and times the low phase
		if (!r_reg.rsn_s2)
		begin
			if (r_reg.low_cnt != 16'hffff)
				r_next.low_cnt = r_reg.low_cnt + 16'h1;
			r_next.seq = CFL_IDLE;
			r_next.user_mode = 1'b0;
			r_next.spi = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
			r_next.mpm_rd = 1'b0;
		end
		else
			// Any high cycle restarts the count: short pulses never add up
			r_next.low_cnt = 16'h0;

		// Data pin follows the command shifter
		r_next.spi.mosi = r_next.tx[39];
	end

	// System state register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			r_reg <= '0;
			r_reg.seq <= CFL_IDLE;
			r_reg.spi.cs_n <= 1'b1;
			// Synchronisers rest at the pin's idle level: no false rise
			r_reg.rsn_s1 <= 1'b1;
			r_reg.rsn_s2 <= 1'b1;
			r_reg.rsn_prev <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Byte buffer between fetch and the cell writer
	cfl_fifo #(
		.WIDTH(`CFL_BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst(rst),
		.in_valid(r_reg.pend_valid),
		.in_ready(fifo_in_ready),
		.in_data(r_reg.pend_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Outputs straight from state
	assign flash_spi = r_reg.spi;
	assign mpm_rd_en = r_reg.mpm_rd;
	assign mpm_addr = r_reg.mpm_addr;
	assign cmem_wr = r_reg.cmem;
	assign user_mode = r_reg.user_mode;
	assign cfg_busy = (r_reg.seq != CFL_IDLE) && !r_reg.user_mode;
	assign link_overrun = r_reg.overrun;

endmodule // cfl_loader

// *** logic/cfl_params.svh ***
// Constants of the configuration loader: opcodes, timing and sizes.
// Assumes a 10 MHz system clock; included by the buffer and the loader.
`ifndef CFL_PARAMS_SVH
`define CFL_PARAMS_SVH

// System clock period in ns
`define CFL_SYS_CLK_NS 100
// Least wait between wake-up and fast read, in ns
`define CFL_WAKE_WAIT_NS 30000
// Least wait in cycles, rounded up
`define CFL_WAKE_WAIT_CYC ((`CFL_WAKE_WAIT_NS + `CFL_SYS_CLK_NS - 1) / `CFL_SYS_CLK_NS)
// Least low time of the restart pin, in ns
`define CFL_HOLD_LOW_NS 1000
// Least low time in cycles, rounded up
`define CFL_HOLD_LOW_CYC ((`CFL_HOLD_LOW_NS + `CFL_SYS_CLK_NS - 1) / `CFL_SYS_CLK_NS)
// Cycles per half period of the flash clock
`define CFL_SPI_HALF_CYC 2
// Flash opcodes
`define CFL_OP_WAKE 8'hab
`define CFL_OP_FAST_READ 8'h0b
// Start address and dummy byte of the fast read
`define CFL_START_ADDR 24'h000000
`define CFL_DUMMY_BYTE 8'h00
// Bits shifted out per command
`define CFL_WAKE_BITS 6'h08
`define CFL_READ_BITS 6'h28
// Default bitstream size in bytes
`define CFL_CFG_BYTES 4096
// Buffer shape
`define CFL_FIFO_DEPTH 32
`define CFL_BYTE_W 8

`endif

// *** logic/cfl_pkg.sv ***
// Types shared by the configuration loader and its buffer.
// Assumes the constants header sits beside it.
package cfl_pkg;

	// Sequencer states, one-hot
	typedef enum logic [7:0] {
		CFL_IDLE   = 8'h01,
		CFL_WAKE   = 8'h02,
		CFL_WAIT   = 8'h04,
		CFL_RDCMD  = 8'h08,
		CFL_STREAM = 8'h10,
		CFL_LINK   = 8'h20,
		CFL_MASK   = 8'h40,
		CFL_DONE   = 8'h80
	} cfl_seq_e;

	// Strap code of the load method
	typedef enum logic [1:0] {
		CFL_M_ACTIVE  = 2'h0,
		CFL_M_PASSIVE = 2'h1,
		CFL_M_JTAG    = 2'h2,
		CFL_M_MASK    = 2'h3
	} cfl_mode_e;

	// Flash pins driven by the device
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} cfl_spi_s;

	// One write into the configuration cells
	typedef struct packed {
		logic valid;
		logic [23:0] addr;
		logic [7:0] data;
	} cfl_cmem_s;

	// Whole system-domain state of the loader
	typedef struct packed {
		cfl_seq_e seq;
		cfl_mode_e mode;
		logic rsn_s1;
		logic rsn_s2;
		logic rsn_prev;
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic miso_s1;
		logic miso_s2;
		logic tog_s1;
		logic tog_s2;
		logic tog_prev;
		logic [15:0] low_cnt;
		logic [15:0] wait_cnt;
		logic [7:0] div_cnt;
		logic [5:0] bit_cnt;
		logic [39:0] tx;
		logic [7:0] rx;
		logic [2:0] rx_bits;
		cfl_spi_s spi;
		logic pend_valid;
		logic [7:0] pend_data;
		logic [23:0] fetch_cnt;
		logic mpm_rd;
		logic [23:0] mpm_addr;
		cfl_cmem_s cmem;
		logic [23:0] wr_cnt;
		logic user_mode;
		logic overrun;
	} cfl_sys_s;

	// Whole link-domain state
	typedef struct packed {
		logic [6:0] sr;
		logic [2:0] cnt;
		logic [7:0] hold;
		logic tog;
	} cfl_link_s;

endpackage

// *** sim/cfl_flash_model.sv ***
// Behavioural serial flash answering the loader's fast read.
// Assumes mode 0 framing: sample on clock rise, shift on clock fall.
`timescale 1ns/1ps

module cfl_flash_model
(
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic [39:0] frm0,
	output logic [39:0] frm1
);
	int nb = 0;
	int nf = 0;
	logic [39:0] sh = 40'h0;
	logic [7:0] byt;
	logic in_frame = 1'b0;
	// Content of byte k of the stored bitstream
	function automatic logic [7:0] pat(input int k);
		return 8'(k * 29) ^ 8'ha5;
	endfunction
	initial miso = 1'b0;
	initial frm0 = 40'h0;
	initial frm1 = 40'h0;
	// New frame restarts the bit count
	always @(negedge cs_n)
	begin
		nb = 0;
		sh = 40'h0;
		in_frame = 1'b1;
	end
	// released line inverts; only a real frame is logged, not the reset rise
	always @(posedge cs_n)
	begin
		if (in_frame)
		begin
			if (nf == 0) frm0 = sh;
			if (nf == 1) frm1 = sh;
			nf++;
		end
		in_frame = 1'b0;
		miso = ~miso;
	end
	// Command bits captured on rise
	always @(posedge sclk)
	begin
		if (!cs_n)
		begin
			if (nb < 40) sh = {sh[38:0], mosi};
			nb++;
		end
	end
	always @(negedge sclk)
	begin
		if (!cs_n && nb >= 40)
		begin
			byt = pat((nb - 40) / 8);
			miso = byt[7 - (nb - 40) % 8];
		end
	end
endmodule // cfl_flash_model

// *** sim/cfl_loader_asserts.sv ***
// Port checker for the configuration loader.
// Assumes it is bound onto cfl_loader and sees its ports only.
`timescale 1ns/1ps

module cfl_loader_asserts
	import cfl_pkg::*;
#(
	parameter int WAKE_WAIT_CYC = 300,
	parameter int CFG_BYTES = 4096
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic configuration_restart_n,
	input cfl_spi_s flash_spi,
	input wire logic mpm_rd_en,
	input cfl_cmem_s cmem_wr,
	input wire logic cmem_wr_ready,
	input wire logic user_mode,
	input wire logic cfg_busy
);
	////////////////////////////////////////////////////////////////
	// Select high time and first-frame flag
	logic [15:0] gap_reg;
	logic seen_reg;
	logic [23:0] acc_reg;
	// Counts select-high cycles; the first frame has no wake before it
	// Accepted cell writes counted per load, cleared while the pin is low
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			gap_reg <= 16'h0000;
			seen_reg <= 1'b0;
			acc_reg <= 24'h000000;
		end
		else
		begin
			gap_reg <= flash_spi.cs_n ? gap_reg + 16'h0001 : 16'h0000;
			seen_reg <= seen_reg | ~flash_spi.cs_n;
			acc_reg <= !configuration_restart_n ? 24'h000000 : acc_reg + {23'h000000, cmem_wr.valid && cmem_wr_ready};
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Clock high for two cycles, then low
	sequence s_sclk_high;
		flash_spi.sclk [*2] ##1 !flash_spi.sclk;
	endsequence
	property p_user_busy; $rose(user_mode) |-> !cmem_wr.valid && acc_reg == 24'(CFG_BYTES); endproperty
	a_user_busy: assert property (p_user_busy) else $error("user mode during load");
	property p_restart_drop; !configuration_restart_n [*4] |-> !user_mode; endproperty
	a_restart_drop: assert property (p_restart_drop) else $error("user mode kept with pin low");
	property p_wake_gap; $fell(flash_spi.cs_n) && seen_reg |-> gap_reg >= WAKE_WAIT_CYC; endproperty
	a_wake_gap: assert property (p_wake_gap) else $error("read issued too soon after wake");
	property p_sclk_frame; flash_spi.sclk |-> !flash_spi.cs_n; endproperty
	a_sclk_frame: assert property (p_sclk_frame) else $error("flash clock outside frame");
	property p_mosi_hold; !flash_spi.cs_n && flash_spi.sclk |-> $stable(flash_spi.mosi); endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("flash data moved while clock high");
	property p_sclk_period; $rose(flash_spi.sclk) |-> s_sclk_high; endproperty
	a_sclk_period: assert property (p_sclk_period) else $error("flash clock high time wrong");
	property p_mpm_pulse; mpm_rd_en |=> !mpm_rd_en; endproperty
	a_mpm_pulse: assert property (p_mpm_pulse) else $error("mask read strobe too long");
	property p_cell_hold;
		cmem_wr.valid && !cmem_wr_ready |=> cmem_wr.valid && $stable(cmem_wr.addr) && $stable(cmem_wr.data);
	endproperty
	a_cell_hold: assert property (p_cell_hold) else $error("cell write dropped before accept");
endmodule // cfl_loader_asserts

bind cfl_loader cfl_loader_asserts #(.WAKE_WAIT_CYC(WAKE_WAIT_CYC), .CFG_BYTES(CFG_BYTES)) u_chk (.sys_clk(sys_clk),
	.rst(rst),
	.configuration_restart_n(configuration_restart_n), .flash_spi(flash_spi), .mpm_rd_en(mpm_rd_en),
	.cmem_wr(cmem_wr), .cmem_wr_ready(cmem_wr_ready), .user_mode(user_mode), .cfg_busy(cfg_busy));

// *** sim/cfl_loader_tb.sv ***
// Self-checking bench of the configuration loader in all four methods.
// Assumes the flash model and the bound checker are compiled beside it.
`timescale 1ns/1ps

module cfl_loader_tb;
	import cfl_pkg::*;
	localparam int NB = 40;
	logic sys_clk = 0, rst = 0, configuration_restart_n = 1, flash_miso;
	logic [1:0] cfg_mode_strap = 2'h0;
	logic link_clk = 0, ps_sel_n = 1, ps_data = 0, jtag_shift_en = 0, jtag_tdi = 0;
	logic mpm_rd_en, user_mode, cfg_busy, link_overrun, cmem_wr_ready = 0, stall = 0;
	logic [23:0] mpm_addr;
	logic [7:0] mpm_data = 8'h00;
	cfl_spi_s flash_spi;
	cfl_cmem_s cmem_wr;
	int num_errors = 0, compares = 0, wcnt = 0;
	////////////////////////////////////////////////////////////////
	cfl_loader #(.CFG_BYTES(NB)) dut (.sys_clk(sys_clk), .rst(rst), .configuration_restart_n(configuration_restart_n),
		.cfg_mode_strap(cfg_mode_strap), .flash_spi(flash_spi), .flash_miso(flash_miso), .link_clk(link_clk),
		.ps_sel_n(ps_sel_n), .ps_data(ps_data), .jtag_shift_en(jtag_shift_en), .jtag_tdi(jtag_tdi),
		.mpm_rd_en(mpm_rd_en), .mpm_addr(mpm_addr), .mpm_data(mpm_data), .cmem_wr(cmem_wr),
		.cmem_wr_ready(cmem_wr_ready), .user_mode(user_mode), .cfg_busy(cfg_busy), .link_overrun(link_overrun));
	cfl_flash_model fl (.sclk(flash_spi.sclk), .cs_n(flash_spi.cs_n), .mosi(flash_spi.mosi), .miso(flash_miso),
		.frm0(), .frm1());
	initial forever #50 sys_clk = ~sys_clk;
	// Mask memory drives data inside the strobe cycle only, zero elsewhere
	always @(negedge sys_clk) mpm_data <= (mpm_rd_en === 1'b1) ? fl.pat(int'(mpm_addr)) : 8'h00;
	// Cell writes judged where settled; ready for the next edge and the judged
	// write both follow one stall value, so no accept is missed
	always @(negedge sys_clk)
	begin
		if (cmem_wr.valid === 1'b1 && !stall)
		begin
			chk("cell_addr", wcnt, cmem_wr.addr);
			chk("cell_data", fl.pat(wcnt), cmem_wr.data);
			wcnt++;
		end
		cmem_wr_ready <= ~stall;
	end
	////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [39:0] e, input logic [39:0] g);
		compares++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task end_sim;
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task do_reset;
		rst = 1'b1;
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
	endtask
	// Restart pin held low past the least time, then raised
	task start(input cfl_mode_e m);
		@(negedge sys_clk);
		cfg_mode_strap = m;
		configuration_restart_n = 1'b0;
		repeat (15) @(negedge sys_clk);
		wcnt = 0;
		configuration_restart_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk("busy", 1, cfg_busy);
	endtask
	task wait_done;
		for (int i = 0; i < 20000 && user_mode !== 1'b1; i++) @(negedge sys_clk);
		chk("user_mode", 1, user_mode);
		chk("writes", NB, wcnt);
	endtask
	// Link clock runs only inside the frame
	task send_link(input logic jt);
		logic [7:0] v;
		#37;
		if (jt) jtag_shift_en = 1'b1;
		else ps_sel_n = 1'b0;
		for (int k = 0; k < NB; k++)
		begin
			v = fl.pat(k);
			for (int b = 7; b >= 0; b--)
			begin
				ps_data = jt ? ~v[b] : v[b];
				jtag_tdi = jt ? v[b] : ~v[b];
				#80 link_clk = 1'b1;
				#80 link_clk = 1'b0;
			end
		end
		ps_sel_n = 1'b1;
		jtag_shift_en = 1'b0;
		ps_data = ~ps_data;
		jtag_tdi = ~jtag_tdi;
	endtask
	////////////////////////////////////////////////////////////////
	task t_active;
		stall = 1'b1;
		start(CFL_M_ACTIVE);
		repeat (2200) @(negedge sys_clk);
		chk("stall_sclk", 0, flash_spi.sclk);
		chk("stall_cs", 0, flash_spi.cs_n);
		stall = 1'b0;
		wait_done;
		chk("wake_frame", 40'h00000000ab, fl.frm0);
		chk("read_frame", 40'h0b00000000, fl.frm1);
	endtask
	task t_passive;
		do_reset;
		start(CFL_M_PASSIVE);
		send_link(1'b0);
		wait_done;
		chk("overrun", 0, link_overrun);
	endtask
	// Stalled cells: link bytes beyond the buffer are lost and flagged
	task t_overrun;
		stall = 1'b1;
		start(CFL_M_PASSIVE);
		send_link(1'b0);
		repeat (8) @(negedge sys_clk);
		chk("overrun", 1, link_overrun);
		chk("user_mode", 0, user_mode);
		stall = 1'b0;
		repeat (100) @(negedge sys_clk);
	endtask
	task t_jtag;
		start(CFL_M_JTAG);
		send_link(1'b1);
		wait_done;
	endtask
	task t_mask;
		start(CFL_M_MASK);
		wait_done;
	endtask
	// Short low pulse drops user mode but starts nothing
	task t_abort;
		@(negedge sys_clk);
		configuration_restart_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		configuration_restart_n = 1'b1;
		repeat (20) @(negedge sys_clk);
		chk("user_mode", 0, user_mode);
		chk("busy", 0, cfg_busy);
	endtask
	initial
	begin
		do_reset;
		t_active;
		t_passive;
		t_overrun;
		t_jtag;
		t_mask;
		t_abort;
		end_sim;
	end
	// Watchdog well past the expected run of some 4300 cycles
	initial
	begin
		#2000000;
		num_errors++;
		end_sim;
	end
endmodule // cfl_loader_tb
